// *** core/sar_adc_defines.svh ***
// register offsets, field positions, reset values and timing codes of the converter sequencer
// assumes an 8-bit register port with byte addresses
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PIN_EN 8'h08
`define ADDR_CTRL 8'h09
`define ADDR_OFFSET 8'h0a
`define ADDR_RES_UP 8'h0b
`define ADDR_RES_HI 8'h0c
`define ADDR_RES_LO 8'h0d
`define ADDR_STATUS 8'h0e
`define ADDR_OSC_SW 8'h0f

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_EXT_REF 7
`define CTRL_DIV_HI 6
`define CTRL_DIV_LO 5
`define CTRL_RUN 4
`define CTRL_PWR 3
`define CTRL_CH_HI 2
`define CTRL_CH_LO 0

// ----------------------------------------------------------------
// offset register fields
// ----------------------------------------------------------------
`define OFS_CAL 7
`define OFS_SIGN 6
`define OFS_MAG_HI 5
`define OFS_MAG_LO 3
`define OFS_REF_HI 2
`define OFS_REF_LO 1
`define OFS_INT_CH 0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STS_DONE 0
`define STS_IRQ_EN 1
`define STS_WAKE_EN 2
`define STS_WAKE 3

// ----------------------------------------------------------------
// oscillator switch fields
// ----------------------------------------------------------------
`define OSC_SHS_HI 3
`define OSC_SHS_LO 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL 8'h00
`define RST_OFFSET 8'h00
`define RST_OSC_SW 8'h0c
`define RST_PIN_EN 8'h00

// ----------------------------------------------------------------
// divider and timing
// ----------------------------------------------------------------
`define DIV_16 2'b00
`define DIV_4 2'b01
`define DIV_64 2'b10
`define DIV_1 2'b11
`define DIVN_16 6'd15
`define DIVN_4 6'd3
`define DIVN_64 6'd63
`define DIVN_1 6'd0
`define SHS_2 4'd2
`define SHS_4 4'd4
`define SHS_8 4'd8
`define SHS_12 4'd12
`define BIT_COUNT 4'd12
`define OFS_MAG_SHIFT 1

`endif

// *** core/sar_adc_pkg.sv ***
// types of the converter sequencer; its clock divider does not use them
// assumes the defines header is compiled in the same unit
package sar_adc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_SAMPLE,
        ST_CONVERT,
        ST_FINISH
    } seq_state_t;
endpackage : sar_adc_pkg

// *** core/sar_tick_if.sv ***
// carrier between the sequencer and its converter clock divider
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface sar_tick_if;
    logic [1:0] div_sel;
    logic low_speed;
    logic sub_tick;
    logic enable;
    logic tick;
    logic half_tick;
    modport ctrl (output div_sel, output low_speed, output sub_tick, output enable,
                  input tick, input half_tick);
    modport gen (input div_sel, input low_speed, input sub_tick, input enable,
                 output tick, output half_tick);
endinterface : sar_tick_if
`default_nettype wire

// *** core/sar_tick_gen.sv ***
// converter clock divider: one-cycle enable per converter period and one at its half
// assumes sub_tick is a synchronised one-cycle pulse at the sub-clock rate
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_tick_gen (
    input wire logic clk,
    input wire logic rstn,
    sar_tick_if.gen tif
);
    typedef struct packed {
        logic [5:0] cnt;
        logic sub_half;
        logic tick;
        logic half_tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;
    logic [5:0] div_n;

    always_comb begin
        case (tif.div_sel)
            `DIV_16: div_n = `DIVN_16;
            `DIV_4: div_n = `DIVN_4;
            `DIV_64: div_n = `DIVN_64;
            `DIV_1: div_n = `DIVN_1;
            default: div_n = `DIVN_16;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        s_d.half_tick = 1'b0;
        if (!tif.enable) begin
            s_d.cnt = 6'd0;
            s_d.sub_half = 1'b0;
        end else if (tif.low_speed) begin
            // half period on the sub clock is one sub pulse: alternate half_tick and tick
            if (tif.sub_tick) begin
                s_d.sub_half = ~s_q.sub_half;
                s_d.tick = s_q.sub_half;
                s_d.half_tick = ~s_q.sub_half;
            end
        end else if (s_q.cnt >= div_n) begin
            s_d.cnt = 6'd0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 6'd1;
            s_d.half_tick = (s_q.cnt == (div_n >> 1));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.tick = s_q.tick;
    assign tif.half_tick = s_q.half_tick | (div_n == `DIVN_1 && s_q.tick && !tif.low_speed);
endmodule : sar_tick_gen
`default_nettype wire

// *** core/sar_adc_sequencer.sv ***
// successive-approximation converter sequencer with its register port
// assumes the analog macro answers comp_high within one converter period of a trial code
//
// Implementation choice: strobed register access.
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer #(
    parameter int RES_W = 12
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic sleep_mode,
    input wire logic global_irq_on,
    input wire logic sub_clk_pin,
    input wire logic comp_high_pin,
    output logic [7:0] analog_pin_en,
    output logic ext_ref_sel,
    output logic res_ref_on,
    output logic conv_power_on,
    output logic [2:0] mux_sel,
    output logic mux_internal,
    output logic mux_quarter_vdd,
    output logic sample_on,
    output logic [RES_W-1:0] dac_code,
    output logic offset_cal_en,
    output logic offset_positive,
    output logic [3:0] offset_lsb,
    output logic [1:0] int_ref_sel,
    output logic int_ref_on,
    output logic core_wake,
    output logic irq_vector_req
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        sar_adc_pkg::seq_state_t st;
        logic [7:0] pin_en;
        logic [7:0] ctrl;
        logic [7:0] ofs;
        logic [7:0] osc;
        logic done;
        logic irq_en;
        logic wake_en;
        logic wake;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] sar;
        logic [3:0] cnt;
        logic read_seen;
        logic shut;
        logic [7:0] rdata;
        logic sample_on;
        logic core_wake;
        logic vec;
        logic [1:0] sub_sync;
        logic sub_prev;
        logic [1:0] comp_sync;
        logic [1:0] settle;
    } seq_t;

    seq_t s_q;
    seq_t s_d;
    logic [3:0] sample_len;
    logic finishing;
    logic [2:0] new_ch;
    logic new_int;

    sar_tick_if tif ();

    sar_tick_gen u_tick (
        .clk(clk),
        .rstn(rstn),
        .tif(tif)
    );

    assign tif.div_sel = s_q.ctrl[`CTRL_DIV_HI:`CTRL_DIV_LO];
    assign tif.low_speed = s_q.osc[`OSC_SHS_HI + 1]; // low-speed mode bit of the switch register
    assign tif.sub_tick = s_q.sub_sync[1] & ~s_q.sub_prev;
    assign tif.enable = (s_q.st != sar_adc_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // sample length decode
    // ----------------------------------------------------------------
    always_comb begin
        case (s_q.osc[`OSC_SHS_HI:`OSC_SHS_LO])
            2'b00: sample_len = `SHS_2;
            2'b01: sample_len = `SHS_4;
            2'b10: sample_len = `SHS_8;
            2'b11: sample_len = `SHS_12;
            default: sample_len = `SHS_12;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sub_sync = {s_q.sub_sync[0], sub_clk_pin};
        s_d.sub_prev = s_q.sub_sync[1];
        s_d.comp_sync = {s_q.comp_sync[0], comp_high_pin};
        s_d.core_wake = 1'b0;
        s_d.vec = 1'b0;
        s_d.settle = s_q.settle >> 1;
        finishing = 1'b0;
        new_ch = wdata[`CTRL_CH_HI:`CTRL_CH_LO];
        new_int = wdata[`OFS_INT_CH];
        if (!sleep_mode) begin
            s_d.shut = 1'b0;
        end

        // sequencer; keeps running whether or not the core sleeps
        case (s_q.st)
            sar_adc_pkg::ST_IDLE: begin
                s_d.sample_on = 1'b0;
            end
            sar_adc_pkg::ST_DELAY: begin
                if (tif.half_tick) begin
                    s_d.st = sar_adc_pkg::ST_SAMPLE;
                    s_d.sample_on = 1'b1;
                    s_d.cnt = 4'd0;
                end
            end
            sar_adc_pkg::ST_SAMPLE: begin
                if (tif.half_tick) begin
                    if (s_q.cnt + 4'd1 >= sample_len) begin
                        s_d.st = sar_adc_pkg::ST_CONVERT;
                        s_d.settle = '1;
                        s_d.sample_on = 1'b0;
                        s_d.cnt = 4'd0;
                        s_d.sar = {1'b1, {(RES_W-1){1'b0}}};
                    end else begin
                        s_d.cnt = s_q.cnt + 4'd1;
                    end
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                // msb first; settle waits out the comparator synchroniser at divide-by-one
                if (tif.half_tick && s_q.settle == '0) begin
                    s_d.settle = '1;
                    for (int i = 0; i < RES_W; i++) begin
                        if (i == RES_W - 1 - int'(s_q.cnt)) begin
                            s_d.sar[i] = s_q.comp_sync[1];
                            if (i > 0) begin
                                s_d.sar[i-1] = 1'b1;
                            end
                        end
                    end
                    if (s_q.cnt + 4'd1 >= `BIT_COUNT) begin
                        s_d.st = sar_adc_pkg::ST_FINISH;
                    end else begin
                        s_d.cnt = s_q.cnt + 4'd1;
                    end
                end
            end
            sar_adc_pkg::ST_FINISH: begin
                finishing = 1'b1;
                s_d.st = sar_adc_pkg::ST_IDLE;
                s_d.result = s_q.sar;
                s_d.read_seen = 1'b0;
                s_d.ctrl[`CTRL_RUN] = 1'b0;
                if (s_q.irq_en) begin
                    s_d.core_wake = 1'b1;
                    s_d.vec = global_irq_on;
                end else if (sleep_mode) begin
                    s_d.shut = 1'b1;
                end
            end
            default: s_d.st = sar_adc_pkg::ST_IDLE;
        endcase

        // register writes
        if (wr_en) begin
            case (addr)
                `ADDR_PIN_EN: s_d.pin_en = wdata;
                `ADDR_CTRL: begin
                    s_d.ctrl[`CTRL_EXT_REF] = wdata[`CTRL_EXT_REF];
                    s_d.ctrl[`CTRL_DIV_HI:`CTRL_DIV_LO] = wdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
                    s_d.ctrl[`CTRL_PWR] = wdata[`CTRL_PWR];
                    if (!s_q.done && !s_q.ctrl[`CTRL_RUN]) begin
                        s_d.ctrl[`CTRL_CH_HI:`CTRL_CH_LO] = new_ch;
                        if (s_q.read_seen && new_ch != s_q.ctrl[`CTRL_CH_HI:`CTRL_CH_LO]) begin
                            s_d.result = '0;
                        end
                    end
                    if (wdata[`CTRL_RUN] && s_q.st == sar_adc_pkg::ST_IDLE) begin
                        s_d.ctrl[`CTRL_RUN] = 1'b1;
                        s_d.st = sar_adc_pkg::ST_DELAY;
                        s_d.shut = 1'b0;
                    end
                end
                `ADDR_OFFSET: begin
                    s_d.ofs[7:1] = wdata[7:1];
                    if (!s_q.done && !s_q.ctrl[`CTRL_RUN]) begin
                        s_d.ofs[`OFS_INT_CH] = new_int;
                    end
                end
                `ADDR_STATUS: begin
                    // done flag: software may only clear it, completion wins
                    if (!wdata[`STS_DONE]) begin
                        s_d.done = 1'b0;
                    end
                    if (!wdata[`STS_WAKE]) begin
                        s_d.wake = 1'b0;
                    end
                    s_d.irq_en = wdata[`STS_IRQ_EN];
                    s_d.wake_en = wdata[`STS_WAKE_EN];
                end
                `ADDR_OSC_SW: s_d.osc = wdata;
                default: ;
            endcase
        end

        // completion sets win over a same-cycle clear
        if (finishing) begin
            s_d.done = s_q.irq_en ? 1'b1 : s_d.done;
            s_d.wake = s_q.wake_en ? 1'b1 : s_d.wake;
        end

        // register reads, data valid in the following cycle
        s_d.rdata = 8'h00;
        if (rd_en) begin
            case (addr)
                `ADDR_PIN_EN: s_d.rdata = s_q.pin_en;
                `ADDR_CTRL: s_d.rdata = s_q.ctrl;
                `ADDR_OFFSET: s_d.rdata = s_q.ofs;
                `ADDR_RES_UP: s_d.rdata = s_q.result[11:4];
                `ADDR_RES_HI: s_d.rdata = {4'h0, s_q.result[11:8]};
                `ADDR_RES_LO: s_d.rdata = s_q.result[7:0];
                `ADDR_STATUS: s_d.rdata = {4'h0, s_q.wake, s_q.wake_en, s_q.irq_en, s_q.done};
                `ADDR_OSC_SW: s_d.rdata = s_q.osc;
                default: s_d.rdata = 8'h00;
            endcase
            if (addr == `ADDR_RES_UP || addr == `ADDR_RES_HI || addr == `ADDR_RES_LO) begin
                s_d.read_seen = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= sar_adc_pkg::ST_IDLE;
            s_q.ctrl <= `RST_CTRL;
            s_q.ofs <= `RST_OFFSET;
            s_q.osc <= `RST_OSC_SW;
            s_q.pin_en <= `RST_PIN_EN;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign rdata = s_q.rdata;
    assign analog_pin_en = s_q.pin_en;
    assign ext_ref_sel = s_q.ctrl[`CTRL_EXT_REF];
    // shut latch overrides power bit after an unattended completion in sleep
    assign res_ref_on = s_q.ctrl[`CTRL_PWR] & ~s_q.shut;
    assign conv_power_on = s_q.ctrl[`CTRL_PWR] & ~s_q.shut;
    assign mux_sel = s_q.ctrl[`CTRL_CH_HI:`CTRL_CH_LO];
    assign mux_internal = s_q.ofs[`OFS_INT_CH];
    assign mux_quarter_vdd = s_q.ofs[`OFS_INT_CH] & s_q.ctrl[`CTRL_CH_HI];
    assign sample_on = s_q.sample_on;
    assign dac_code = s_q.sar;
    assign offset_cal_en = s_q.ofs[`OFS_CAL];
    assign offset_positive = s_q.ofs[`OFS_SIGN];
    assign offset_lsb = {s_q.ofs[`OFS_MAG_HI:`OFS_MAG_LO], 1'b0};
    assign int_ref_sel = s_q.ofs[`OFS_REF_HI:`OFS_REF_LO];
    assign int_ref_on = |s_q.ofs[`OFS_REF_HI:`OFS_REF_LO];
    assign core_wake = s_q.core_wake;
    assign irq_vector_req = s_q.vec;
endmodule : sar_adc_sequencer
`default_nettype wire

// *** test/sar_adc_sequencer_asserts.sv ***
// concurrent checks on the converter sequencer top ports
// assumes one clock domain; bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic global_irq_on,
    input wire logic res_ref_on,
    input wire logic conv_power_on,
    input wire logic [2:0] mux_sel,
    input wire logic mux_internal,
    input wire logic mux_quarter_vdd,
    input wire logic sample_on,
    input wire logic [3:0] offset_lsb,
    input wire logic [1:0] int_ref_sel,
    input wire logic int_ref_on,
    input wire logic core_wake,
    input wire logic irq_vector_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    property p_vec_wake;
        irq_vector_req |-> core_wake;
    endproperty
    a_vec_wake: assert property (p_vec_wake)
        else $error("vector request without wake pulse");
    property p_vec_gi;
        core_wake && global_irq_on |-> irq_vector_req;
    endproperty
    a_vec_gi: assert property (p_vec_gi)
        else $error("wake with interrupts on but no vector request");
    property p_wake_pulse;
        core_wake |=> !core_wake;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse longer than one cycle");
    property p_ref_on;
        int_ref_on == (int_ref_sel != 2'b00);
    endproperty
    a_ref_on: assert property (p_ref_on)
        else $error("reference generator state disagrees with select");
    property p_ofs_even;
        offset_lsb[0] == 1'b0;
    endproperty
    a_ofs_even: assert property (p_ofs_even)
        else $error("odd offset magnitude");
    property p_quarter;
        mux_quarter_vdd |-> mux_internal && mux_sel[2];
    endproperty
    a_quarter: assert property (p_quarter)
        else $error("quarter supply routed without its code");
    property p_pwr;
        res_ref_on == conv_power_on;
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("resistor reference and power disagree");
    property p_samp_min;
        $fell(sample_on) |-> $past(sample_on, 2);
    endproperty
    a_samp_min: assert property (p_samp_min)
        else $error("sampling phase shorter than two cycles");
    property p_mux_hold;
        sample_on |=> $stable(mux_sel);
    endproperty
    a_mux_hold: assert property (p_mux_hold)
        else $error("channel moved during sampling");
    property p_rd_idle;
        !$past(rd_en) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
endmodule : sar_adc_sequencer_asserts
`default_nettype wire

// *** test/sar_analog_model.sv ***
// behavioural analog front end: input multiplexer, sample-hold, comparator
// assumes dac_code carries the trial code while bits are decided
`timescale 1ns/1ps
`default_nettype none
module sar_analog_model (
    input wire logic [2:0] mux_sel,
    input wire logic mux_internal,
    input wire logic mux_quarter_vdd,
    input wire logic sample_on,
    input wire logic [11:0] dac_code,
    output logic comp_high_pin
);
    logic [11:0] level;
    logic [11:0] held = 12'h000;
    always_comb begin
        if (mux_internal && mux_quarter_vdd) begin
            level = 12'h400;
        end else if (mux_internal) begin
            level = 12'h2c3;
        end else begin
            level = {mux_sel, 9'h0a5};
        end
    end
    // hold what was sampled; input sits half a step above level
    always @(sample_on or level) begin
        if (sample_on) begin
            held = level;
        end
    end
    assign comp_high_pin = (held >= dac_code);
endmodule : sar_analog_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the converter sequencer and its analog model
// assumes the defines header on the include path
`include "sar_adc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic sleep_mode = 1'b0, global_irq_on = 1'b1, sub_clk_pin = 1'b0, comp_high_pin;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, analog_pin_en;
    logic ext_ref_sel, res_ref_on, conv_power_on, mux_internal, mux_quarter_vdd, sample_on;
    logic offset_cal_en, offset_positive, int_ref_on, core_wake, irq_vector_req;
    logic [2:0] mux_sel;
    logic [11:0] dac_code;
    logic [3:0] offset_lsb;
    logic [1:0] int_ref_sel;
    int n_fail = 0, checks_done = 0, wake_cnt = 0, vec_cnt = 0, samp_cnt = 0;
    int divs[4] = '{16, 4, 64, 1};
    int samps[4] = '{2, 4, 8, 12};

    sar_adc_sequencer u_sar_adc_sequencer (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .sleep_mode(sleep_mode), .global_irq_on(global_irq_on), .sub_clk_pin(sub_clk_pin),
        .comp_high_pin(comp_high_pin), .analog_pin_en(analog_pin_en),
        .ext_ref_sel(ext_ref_sel), .res_ref_on(res_ref_on), .conv_power_on(conv_power_on),
        .mux_sel(mux_sel), .mux_internal(mux_internal), .mux_quarter_vdd(mux_quarter_vdd),
        .sample_on(sample_on), .dac_code(dac_code), .offset_cal_en(offset_cal_en),
        .offset_positive(offset_positive), .offset_lsb(offset_lsb),
        .int_ref_sel(int_ref_sel), .int_ref_on(int_ref_on), .core_wake(core_wake),
        .irq_vector_req(irq_vector_req));
    sar_analog_model u_sar_analog_model (.mux_sel(mux_sel), .mux_internal(mux_internal),
        .mux_quarter_vdd(mux_quarter_vdd), .sample_on(sample_on), .dac_code(dac_code),
        .comp_high_pin(comp_high_pin));

    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        forever #80 sub_clk_pin = ~sub_clk_pin;
    end
    always @(posedge clk) begin
        if (sample_on === 1'b1) samp_cnt <= samp_cnt + 1;
        if (core_wake === 1'b1) wake_cnt <= wake_cnt + 1;
        if (irq_vector_req === 1'b1) vec_cnt <= vec_cnt + 1;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        bus_rd(a, d);
        check(what, d, exp);
    endtask : rd_chk
    // c without run bit; s status; o oscillator switch; samp expected sampling cycles
    task automatic conv_once(input logic [7:0] c, input logic [7:0] s, input logic [7:0] o,
                             input int samp);
        logic [7:0] d;
        logic [11:0] lvl;
        int w0, v0, s0, i;
        lvl = {c[2:0], 9'h0a5};
        w0 = wake_cnt;
        v0 = vec_cnt;
        s0 = samp_cnt;
        bus_wr(`ADDR_OSC_SW, o);
        bus_wr(`ADDR_STATUS, s);
        bus_wr(`ADDR_CTRL, c | 8'h10);
        rd_chk(`ADDR_CTRL, c | 8'h10, "run set");
        bus_wr(`ADDR_CTRL, c ^ 8'h01);
        rd_chk(`ADDR_CTRL, c | 8'h10, "run kept");
        for (i = 0; i < 1000; i++) begin
            bus_rd(`ADDR_CTRL, d);
            if (d[4] === 1'b0) break;
        end
        if (i == 1000) begin
            n_fail++;
            finish_test();
        end
        check("sampling cycles", samp_cnt - s0, samp);
        rd_chk(`ADDR_RES_UP, lvl[11:4], "result upper");
        rd_chk(`ADDR_RES_HI, {4'h0, lvl[11:8]}, "result nibble");
        rd_chk(`ADDR_RES_LO, lvl[7:0], "result low");
        bus_rd(`ADDR_STATUS, d);
        check("done flag", d[0], s[1]);
        check("wake pulses", wake_cnt - w0, s[1]);
        check("vector pulses", vec_cnt - v0, s[1] & global_irq_on);
    endtask : conv_once

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rd_chk(`ADDR_CTRL, 8'h00, "ctrl reset");
        rd_chk(`ADDR_OFFSET, 8'h00, "offset reset");
        rd_chk(`ADDR_OSC_SW, 8'h0c, "osc reset");
        rd_chk(`ADDR_PIN_EN, 8'h00, "pin reset");
        bus_wr(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00, "unmapped");
        bus_wr(`ADDR_PIN_EN, 8'ha5);
        rd_chk(`ADDR_PIN_EN, 8'ha5, "pin enable");
        check("pin port", analog_pin_en, 8'ha5);
        $display("test_reset done");
    endtask : test_reset
    task automatic test_offset();
        logic [7:0] v;
        for (int i = 0; i < 256; i++) begin
            v = i[7:0];
            bus_wr(`ADDR_OFFSET, v);
            check("cal", offset_cal_en, v[7]);
            check("sign", offset_positive, v[6]);
            check("mag", offset_lsb, {v[5:3], 1'b0});
            check("ref sel", int_ref_sel, v[2:1]);
            check("ref on", int_ref_on, |v[2:1]);
            check("internal", mux_internal, v[0]);
        end
        check("power off", conv_power_on, 1'b0);
        bus_wr(`ADDR_OFFSET, 8'h00);
        $display("test_offset done");
    endtask : test_offset
    task automatic test_mux();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            bus_wr(`ADDR_CTRL, {v[3], 4'b0001, v[2:0]});
            bus_wr(`ADDR_OFFSET, {7'h00, v[3]});
            check("chan", mux_sel, v[2:0]);
            check("quarter", mux_quarter_vdd, v[3] & v[2]);
            check("ext ref", ext_ref_sel, v[3]);
            check("power", conv_power_on, 1'b1);
            check("res ref", res_ref_on, 1'b1);
        end
        bus_wr(`ADDR_OFFSET, 8'h00);
        bus_wr(`ADDR_CTRL, 8'h00);
        check("res ref off", res_ref_on, 1'b0);
        $display("test_mux done");
    endtask : test_mux
    task automatic test_timing();
        for (int i = 0; i < 4; i++) begin
            conv_once({1'b0, i[1:0], 2'b01, i[1:0], 1'b1}, 8'h02, 8'h00, 2 * divs[i]);
        end
        for (int i = 0; i < 4; i++) begin
            conv_once({5'b00101, i[2:0]}, 8'h02, {4'h0, i[1:0], 2'b00}, 4 * samps[i]);
        end
        conv_once(8'h0c, 8'h02, 8'h10, 128);
        $display("test_timing done");
    endtask : test_timing
    task automatic test_chan();
        global_irq_on <= 1'b0;
        conv_once(8'h0a, 8'h02, 8'h00, 32);
        global_irq_on <= 1'b1;
        bus_wr(`ADDR_CTRL, 8'h0d);
        check("chan while done", mux_sel, 3'd2);
        bus_wr(`ADDR_STATUS, 8'h02);
        bus_wr(`ADDR_CTRL, 8'h0d);
        check("chan free", mux_sel, 3'd5);
        rd_chk(`ADDR_RES_UP, 8'h00, "cleared upper");
        rd_chk(`ADDR_RES_LO, 8'h00, "cleared low");
        $display("test_chan done");
    endtask : test_chan
    task automatic test_sleep();
        logic [7:0] d;
        sleep_mode <= 1'b1;
        conv_once(8'h09, 8'h04, 8'h00, 32);
        bus_rd(`ADDR_STATUS, d);
        check("wake flag", d[3], 1'b1);
        check("shut in sleep", conv_power_on, 1'b0);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("power after sleep", conv_power_on, 1'b1);
        $display("test_sleep done");
    endtask : test_sleep

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        test_reset();
        test_offset();
        test_mux();
        test_timing();
        test_chan();
        test_sleep();
        finish_test();
    end
endmodule : testbench

bind sar_adc_sequencer sar_adc_sequencer_asserts u_sar_adc_sequencer_asserts (
    .clk(clk), .rstn(rstn), .rd_en(rd_en), .rdata(rdata), .global_irq_on(global_irq_on),
    .res_ref_on(res_ref_on), .conv_power_on(conv_power_on), .mux_sel(mux_sel),
    .mux_internal(mux_internal), .mux_quarter_vdd(mux_quarter_vdd), .sample_on(sample_on),
    .offset_lsb(offset_lsb), .int_ref_sel(int_ref_sel), .int_ref_on(int_ref_on),
    .core_wake(core_wake), .irq_vector_req(irq_vector_req));
`default_nettype wire
